// ===== include/aga_pkg.sv
// Shared types and constants for the accumulator-group execution unit.
// Assumes one clock; one instruction state equals one clock cycle.
package aga_pkg;

  typedef enum logic [4:0] {
    OP_PLAIN_SUM,
    OP_SUM_WITH_CARRY,
    OP_PLAIN_DIFFERENCE,
    OP_SUBTRACT_WITH_BORROW,
    OP_LOGICAL_AND,
    OP_LOGICAL_OR,
    OP_EXCLUSIVE_OR,
    OP_COMPARE,
    OP_ACCUMULATOR_INVERT,
    OP_CARRY_INVERT,
    OP_CARRY_FORCE_ONE,
    OP_DECIMAL_ADJUST,
    OP_CIRCULAR_ROTATE_LEFT,
    OP_CIRCULAR_ROTATE_RIGHT,
    OP_ROTATE_LEFT_THROUGH_CARRY,
    OP_ROTATE_RIGHT_THROUGH_CARRY,
    OP_PAIR_SUM_INTO_POINTER,
    OP_DIRECT_ACCUMULATOR_LOAD,
    OP_DIRECT_ACCUMULATOR_STORE,
    OP_INDIRECT_ACCUMULATOR_LOAD,
    OP_INDIRECT_ACCUMULATOR_STORE
  } aga_op_e;

  typedef enum logic [1:0] {
    SRC_REG,
    SRC_MEM,
    SRC_IMM
  } aga_src_e;

  typedef struct packed {
    aga_op_e op;
    aga_src_e src;
    logic [2:0] reg_sel;
    logic [1:0] pair_sel;
    logic [7:0] byte2;
    logic [7:0] byte3;
  } aga_instr_s;

  typedef struct packed {
    logic s;
    logic z;
    logic ac;
    logic p;
    logic c;
  } aga_flags_s;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } aga_mem_s;

  // Cycle counts per instruction class.
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_MEM = 4'h7;
  localparam logic [3:0] CYC_PAIR = 4'ha;
  localparam logic [3:0] CYC_DIRECT = 4'hd;

  // Register file indices; index 6 is the flag byte on the register port.
  localparam logic [2:0] IDX_B = 3'h0;
  localparam logic [2:0] IDX_C = 3'h1;
  localparam logic [2:0] IDX_D = 3'h2;
  localparam logic [2:0] IDX_E = 3'h3;
  localparam logic [2:0] IDX_H = 3'h4;
  localparam logic [2:0] IDX_L = 3'h5;
  localparam logic [2:0] IDX_A = 3'h7;
  localparam logic [3:0] ADDR_L = 4'h5;
  localparam logic [3:0] ADDR_FLAGS = 4'h6;
  localparam logic [3:0] ADDR_A = 4'h7;
  localparam logic [3:0] ADDR_SPL = 4'h8;
  localparam logic [3:0] ADDR_SPH = 4'h9;

  // Flag positions within the flag byte.
  localparam int FLAG_C_BIT = 0;
  localparam int FLAG_P_BIT = 2;
  localparam int FLAG_AC_BIT = 4;
  localparam int FLAG_Z_BIT = 6;
  localparam int FLAG_S_BIT = 7;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_SP = 16'h0000;
  localparam logic [3:0] BCD_MAX = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  function automatic logic op_uses_operand(aga_op_e op);
    return op inside {OP_PLAIN_SUM, OP_SUM_WITH_CARRY, OP_PLAIN_DIFFERENCE,
                      OP_SUBTRACT_WITH_BORROW, OP_LOGICAL_AND, OP_LOGICAL_OR,
                      OP_EXCLUSIVE_OR, OP_COMPARE};
  endfunction

  function automatic logic op_sets_all_flags(aga_op_e op);
    return op_uses_operand(op) || op == OP_DECIMAL_ADJUST;
  endfunction

  function automatic logic op_sets_carry_only(aga_op_e op);
    return op inside {OP_CARRY_INVERT, OP_CARRY_FORCE_ONE, OP_CIRCULAR_ROTATE_LEFT,
                      OP_CIRCULAR_ROTATE_RIGHT, OP_ROTATE_LEFT_THROUGH_CARRY,
                      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_PAIR_SUM_INTO_POINTER};
  endfunction

  function automatic logic op_writes_acc(aga_op_e op);
    return (op_uses_operand(op) && op != OP_COMPARE) ||
           op inside {OP_ACCUMULATOR_INVERT, OP_DECIMAL_ADJUST, OP_CIRCULAR_ROTATE_LEFT,
                      OP_CIRCULAR_ROTATE_RIGHT, OP_ROTATE_LEFT_THROUGH_CARRY,
                      OP_ROTATE_RIGHT_THROUGH_CARRY, OP_DIRECT_ACCUMULATOR_LOAD,
                      OP_INDIRECT_ACCUMULATOR_LOAD};
  endfunction

  function automatic logic op_reads_mem(aga_op_e op, aga_src_e src);
    return (op_uses_operand(op) && src == SRC_MEM) ||
           op inside {OP_DIRECT_ACCUMULATOR_LOAD, OP_INDIRECT_ACCUMULATOR_LOAD};
  endfunction

  function automatic logic [3:0] cycles_of(aga_op_e op, aga_src_e src);
    logic [3:0] n;
    n = CYC_SHORT;
    case (op)
      OP_PAIR_SUM_INTO_POINTER: n = CYC_PAIR;
      OP_DIRECT_ACCUMULATOR_LOAD, OP_DIRECT_ACCUMULATOR_STORE: n = CYC_DIRECT;
      OP_INDIRECT_ACCUMULATOR_LOAD, OP_INDIRECT_ACCUMULATOR_STORE: n = CYC_MEM;
      default:
      begin
        if (op_uses_operand(op) && src != SRC_REG)
        begin
          n = CYC_MEM;
        end
      end
    endcase
    return n;
  endfunction

endpackage

// ===== rtl/aga_alu8.sv
// Combinational 8-bit arithmetic, logic and rotate unit with flag results.
// Assumes the caller selects which flags it keeps.
`timescale 1ns/1ps
module aga_alu8 (
  // Operation and operands
  input wire aga_pkg::aga_op_e op_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] b_i,
  input wire logic carry_i,
  // Result
  output logic [7:0] res_o,
  output aga_pkg::aga_flags_s flags_o
);
  import aga_pkg::*;

  logic is_sub;
  logic [7:0] bx;
  logic ci;
  logic [8:0] wide;
  logic [4:0] low;

  always_comb
  begin
    is_sub = op_i inside {OP_PLAIN_DIFFERENCE, OP_SUBTRACT_WITH_BORROW, OP_COMPARE};
    ci = (op_i inside {OP_SUM_WITH_CARRY, OP_SUBTRACT_WITH_BORROW}) ? carry_i : 1'b0;
    // Subtraction is a plus the inverted operand plus the inverted borrow.
    bx = is_sub ? ~b_i : b_i;
    if (is_sub)
    begin
      ci = ~ci;
    end
    wide = {1'b0, a_i} + {1'b0, bx} + {8'h00, ci};
    low = {1'b0, a_i[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
    res_o = wide[7:0];
    flags_o.c = is_sub ? ~wide[8] : wide[8];
    flags_o.ac = low[4];
    case (op_i)
      OP_LOGICAL_AND:
      begin
        res_o = a_i & b_i;
        flags_o.c = 1'b0;
        flags_o.ac = 1'b0;
      end
      OP_LOGICAL_OR:
      begin
        res_o = a_i | b_i;
        flags_o.c = 1'b0;
        flags_o.ac = 1'b0;
      end
      OP_EXCLUSIVE_OR:
      begin
        res_o = a_i ^ b_i;
        flags_o.c = 1'b0;
        flags_o.ac = 1'b0;
      end
      OP_ACCUMULATOR_INVERT:
      begin
        res_o = ~a_i;
        flags_o.c = carry_i;
      end
      OP_CARRY_INVERT:
      begin
        res_o = a_i;
        flags_o.c = ~carry_i;
      end
      OP_CARRY_FORCE_ONE:
      begin
        res_o = a_i;
        flags_o.c = 1'b1;
      end
      OP_CIRCULAR_ROTATE_LEFT:
      begin
        res_o = {a_i[6:0], a_i[7]};
        flags_o.c = a_i[7];
      end
      OP_CIRCULAR_ROTATE_RIGHT:
      begin
        res_o = {a_i[0], a_i[7:1]};
        flags_o.c = a_i[0];
      end
      OP_ROTATE_LEFT_THROUGH_CARRY:
      begin
        res_o = {a_i[6:0], carry_i};
        flags_o.c = a_i[7];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY:
      begin
        res_o = {carry_i, a_i[7:1]};
        flags_o.c = a_i[0];
      end
      default:
      begin
        res_o = wide[7:0];
      end
    endcase
    flags_o.z = (res_o == 8'h00);
    flags_o.s = res_o[7];
    flags_o.p = ~^res_o;
  end

endmodule

// ===== rtl/aga_dadj.sv
// Combinational decimal correction of the accumulator into two BCD digits.
// Assumes carry and auxiliary carry come from the preceding arithmetic.
`timescale 1ns/1ps
module aga_dadj (
  // Accumulator and incoming flags
  input wire logic [7:0] a_i,
  input wire aga_pkg::aga_flags_s flags_i,
  // Corrected result
  output logic [7:0] res_o,
  output aga_pkg::aga_flags_s flags_o
);
  import aga_pkg::*;

  logic lo_fix;
  logic hi_fix;
  logic [7:0] corr;
  logic [4:0] low;

  always_comb
  begin
    lo_fix = (a_i[3:0] > BCD_MAX) || flags_i.ac;
    hi_fix = (a_i[7:4] > BCD_MAX) || flags_i.c ||
             ((a_i[7:4] == BCD_MAX) && (a_i[3:0] > BCD_MAX));
    corr = {hi_fix ? BCD_FIX : 4'h0, lo_fix ? BCD_FIX : 4'h0};
    res_o = a_i + corr;
    low = {1'b0, a_i[3:0]} + {1'b0, corr[3:0]};
    flags_o.c = flags_i.c || hi_fix;
    flags_o.ac = low[4];
    flags_o.z = (res_o == 8'h00);
    flags_o.s = res_o[7];
    flags_o.p = ~^res_o;
  end

endmodule

// ===== rtl/aga_core.sv
// Accumulator-group execution unit: register file, flags, sequencing and memory port.
// Assumes an external sequencer issues decoded instructions and memory answers
// a read in the cycle after the read strobe.
//
// Overview of operation
// - Add operand plus carry, update five flags.
// - Plain add; register 4, memory 7 cycles.
// - AND into accumulator, carry cleared.
// - OR into accumulator, carry cleared.
// - Invert accumulator, flags untouched, 4 cycles.
// - Invert carry only, 4 cycles.
// - Compare sets flags, accumulator kept.
// - Decimal adjust into two BCD digits.
// - Pair added into HL, carry only, 10.
// - Direct store to high:low address, 13 cycles.
// - Rotate left through carry, carry only.
// - Circular rotate left, bit 7 to carry.
// - Subtract; borrow sets carry, five flags.
// - Subtract with borrow; memory 7, register 4.
// - Set carry to one, nothing else.
// - Flags: zero, sign, even parity, carries.
// - XOR into accumulator, carry cleared.
`timescale 1ns/1ps
module aga_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Instruction issue
  input wire logic issue_i,
  input wire aga_pkg::aga_instr_s instr_i,
  output logic ready_o,
  output logic done_o,
  // Memory port
  output aga_pkg::aga_mem_s mem_o,
  input wire logic [7:0] mem_rdata_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // Status
  output logic [7:0] acc_o,
  output aga_pkg::aga_flags_s flags_o
);
  import aga_pkg::*;

  typedef enum logic {
    ST_IDLE,
    ST_EXEC
  } aga_state_e;

  aga_state_e state_q;
  aga_instr_s instr_q;
  logic [3:0] cnt_q;
  logic rd_pend_q;
  logic [7:0] opnd_q;
  logic [7:0] rf_q [8];
  logic [15:0] sp_q;
  aga_flags_s flags_q;
  aga_mem_s mem_q;
  logic [7:0] rdata_q;

  logic accept;
  logic commit;
  logic idle_we;
  logic [7:0] acc;
  logic [15:0] hl;
  logic [15:0] bc;
  logic [15:0] de;
  logic [15:0] pair_val;
  logic [16:0] pair_sum;
  logic [15:0] addr_d;
  logic [7:0] sel_opnd;
  logic [7:0] alu_res;
  logic [7:0] adj_res;
  logic [7:0] acc_d;
  logic [7:0] flag_byte;
  aga_flags_s alu_flags;
  aga_flags_s adj_flags;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  assign accept = (state_q == ST_IDLE) && issue_i;
  assign commit = (state_q == ST_EXEC) && (cnt_q == 4'h0);
  assign idle_we = reg_we_i && (state_q == ST_IDLE);
  assign ready_o = (state_q == ST_IDLE);
  assign done_o = commit;
  assign mem_o = mem_q;
  assign reg_rdata_o = rdata_q;
  assign acc_o = rf_q[IDX_A];
  assign flags_o = flags_q;
  assign acc = rf_q[IDX_A];
  assign hl = {rf_q[IDX_H], rf_q[IDX_L]};
  assign bc = {rf_q[IDX_B], rf_q[IDX_C]};
  assign de = {rf_q[IDX_D], rf_q[IDX_E]};

  // Sequencing: each instruction holds the unit for its listed state count.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
    end
    else
    begin
      case (state_q)
        ST_IDLE:
        begin
          if (issue_i)
          begin
            state_q <= ST_EXEC;
            cnt_q <= 4'(cycles_of(instr_i.op, instr_i.src) - 4'h1);
          end
        end
        ST_EXEC:
        begin
          if (cnt_q == 4'h0)
          begin
            state_q <= ST_IDLE;
          end
          else
          begin
            cnt_q <= 4'(cnt_q - 4'h1);
          end
        end
        default:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      instr_q <= '0;
    end
    else if (accept)
    begin
      instr_q <= instr_i;
    end
  end

  // Memory address for the instruction being issued.
  always_comb
  begin
    case (instr_i.op)
      OP_DIRECT_ACCUMULATOR_LOAD, OP_DIRECT_ACCUMULATOR_STORE:
      begin
        addr_d = {instr_i.byte3, instr_i.byte2};
      end
      OP_INDIRECT_ACCUMULATOR_LOAD, OP_INDIRECT_ACCUMULATOR_STORE:
      begin
        addr_d = instr_i.pair_sel[0] ? de : bc;
      end
      default:
      begin
        addr_d = hl;
      end
    endcase
  end

  // Memory strobes go out in the cycle after issue.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      mem_q <= '0;
      rd_pend_q <= 1'b0;
    end
    else
    begin
      mem_q.rd <= accept && op_reads_mem(instr_i.op, instr_i.src);
      mem_q.wr <= accept && (instr_i.op inside {OP_DIRECT_ACCUMULATOR_STORE,
                                                OP_INDIRECT_ACCUMULATOR_STORE});
      if (accept)
      begin
        mem_q.addr <= addr_d;
        mem_q.wdata <= acc;
      end
      rd_pend_q <= mem_q.rd;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      opnd_q <= RST_BYTE;
    end
    else if (rd_pend_q)
    begin
      opnd_q <= mem_rdata_i;
    end
  end

  // Operand and result selection.
  always_comb
  begin
    case (instr_q.src)
      SRC_REG: sel_opnd = rf_q[instr_q.reg_sel];
      SRC_MEM: sel_opnd = opnd_q;
      SRC_IMM: sel_opnd = instr_q.byte2;
      default: sel_opnd = RST_BYTE;
    endcase
    case (instr_q.pair_sel)
      2'h0: pair_val = bc;
      2'h1: pair_val = de;
      2'h2: pair_val = hl;
      default: pair_val = sp_q;
    endcase
    pair_sum = {1'b0, hl} + {1'b0, pair_val};
    case (instr_q.op)
      OP_DECIMAL_ADJUST: acc_d = adj_res;
      OP_DIRECT_ACCUMULATOR_LOAD, OP_INDIRECT_ACCUMULATOR_LOAD: acc_d = opnd_q;
      default: acc_d = alu_res;
    endcase
  end

  aga_alu8 u_alu (
    .op_i(instr_q.op),
    .a_i(acc),
    .b_i(sel_opnd),
    .carry_i(flags_q.c),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  aga_dadj u_dadj (
    .a_i(acc),
    .flags_i(flags_q),
    .res_o(adj_res),
    .flags_o(adj_flags)
  );

  // Register file: the port writes only while idle, results land at commit.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      for (int i = 0; i < 8; i++)
      begin
        rf_q[i] <= RST_BYTE;
      end
    end
    else if (idle_we && (reg_addr_i <= ADDR_L || reg_addr_i == ADDR_A))
    begin
      rf_q[reg_addr_i[2:0]] <= reg_wdata_i;
    end
    else if (commit)
    begin
      if (op_writes_acc(instr_q.op))
      begin
        rf_q[IDX_A] <= acc_d;
      end
      if (instr_q.op == OP_PAIR_SUM_INTO_POINTER)
      begin
        rf_q[IDX_H] <= pair_sum[15:8];
        rf_q[IDX_L] <= pair_sum[7:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sp_q <= RST_SP;
    end
    else if (idle_we && reg_addr_i == ADDR_SPL)
    begin
      sp_q[7:0] <= reg_wdata_i;
    end
    else if (idle_we && reg_addr_i == ADDR_SPH)
    begin
      sp_q[15:8] <= reg_wdata_i;
    end
  end

  // Flags: five-flag ops take all, carry-only ops touch carry alone.
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      flags_q <= '0;
    end
    else if (idle_we && reg_addr_i == ADDR_FLAGS)
    begin
      flags_q.c <= reg_wdata_i[FLAG_C_BIT];
      flags_q.p <= reg_wdata_i[FLAG_P_BIT];
      flags_q.ac <= reg_wdata_i[FLAG_AC_BIT];
      flags_q.z <= reg_wdata_i[FLAG_Z_BIT];
      flags_q.s <= reg_wdata_i[FLAG_S_BIT];
    end
    else if (commit && op_sets_all_flags(instr_q.op))
    begin
      flags_q <= (instr_q.op == OP_DECIMAL_ADJUST) ? adj_flags : alu_flags;
    end
    else if (commit && op_sets_carry_only(instr_q.op))
    begin
      flags_q.c <= (instr_q.op == OP_PAIR_SUM_INTO_POINTER) ? pair_sum[16] : alu_flags.c;
    end
  end

  // Register port read data stands for one cycle after the read strobe.
  always_comb
  begin
    flag_byte = 8'h00;
    flag_byte[FLAG_C_BIT] = flags_q.c;
    flag_byte[FLAG_P_BIT] = flags_q.p;
    flag_byte[FLAG_AC_BIT] = flags_q.ac;
    flag_byte[FLAG_Z_BIT] = flags_q.z;
    flag_byte[FLAG_S_BIT] = flags_q.s;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rdata_q <= RST_BYTE;
    end
    else if (!reg_re_i)
    begin
      rdata_q <= RST_BYTE;
    end
    else if (reg_addr_i == ADDR_FLAGS)
    begin
      rdata_q <= flag_byte;
    end
    else if (reg_addr_i <= ADDR_A)
    begin
      rdata_q <= rf_q[reg_addr_i[2:0]];
    end
    else if (reg_addr_i == ADDR_SPL)
    begin
      rdata_q <= sp_q[7:0];
    end
    else if (reg_addr_i == ADDR_SPH)
    begin
      rdata_q <= sp_q[15:8];
    end
    else
    begin
      rdata_q <= RST_BYTE;
    end
  end

  short_timing_a: assert property (
    accept && instr_i.src == SRC_REG && instr_i.op == OP_PLAIN_SUM
    |-> !done_o [*4] ##1 done_o)
    else $error("register add did not finish in 4 cycles");

  mem_timing_a: assert property (
    accept && instr_i.src == SRC_MEM && instr_i.op == OP_SUBTRACT_WITH_BORROW
    |-> ##1 (mem_o.rd && mem_o.addr == $past(hl)) ##6 done_o)
    else $error("memory borrow subtract read or timing wrong");

  pair_timing_a: assert property (
    accept && instr_i.op == OP_PAIR_SUM_INTO_POINTER |-> ##10 done_o)
    else $error("pair add did not finish in 10 cycles");

  store_addr_a: assert property (
    accept && instr_i.op == OP_DIRECT_ACCUMULATOR_STORE
    |-> ##1 (mem_o.wr && mem_o.addr == {$past(instr_i.byte3), $past(instr_i.byte2)}
             && mem_o.wdata == $past(acc)) ##12 done_o)
    else $error("direct store address, data or timing wrong");

  adc_sum_a: assert property (
    commit && instr_q.op == OP_SUM_WITH_CARRY
    |=> acc == 8'($past(acc) + $past(sel_opnd) + {7'h00, $past(flags_q.c)}))
    else $error("add with carry result wrong");

  and_clear_a: assert property (
    commit && instr_q.op == OP_LOGICAL_AND
    |=> !flags_q.c && acc == ($past(acc) & $past(sel_opnd)))
    else $error("logical and result or carry wrong");

  or_clear_a: assert property (
    commit && instr_q.op == OP_LOGICAL_OR
    |=> !flags_q.c && acc == ($past(acc) | $past(sel_opnd)))
    else $error("logical or result or carry wrong");

  xor_clear_a: assert property (
    commit && instr_q.op == OP_EXCLUSIVE_OR
    |=> !flags_q.c && acc == ($past(acc) ^ $past(sel_opnd)))
    else $error("exclusive or result or carry wrong");

  invert_acc_a: assert property (
    commit && instr_q.op == OP_ACCUMULATOR_INVERT |=> acc == ~$past(acc) && $stable(flags_q))
    else $error("accumulator invert wrong or touched flags");

  carry_invert_a: assert property (
    commit && instr_q.op == OP_CARRY_INVERT
    |=> flags_q.c != $past(flags_q.c) && flags_q.z == $past(flags_q.z) && $stable(acc))
    else $error("carry invert wrong");

  carry_set_a: assert property (
    commit && instr_q.op == OP_CARRY_FORCE_ONE
    |=> flags_q.c && flags_q.s == $past(flags_q.s) && $stable(acc))
    else $error("carry set wrong");

  compare_keep_a: assert property (
    commit && instr_q.op == OP_COMPARE
    |=> $stable(acc) && flags_q.z == ($past(acc) == $past(sel_opnd)))
    else $error("compare changed accumulator or zero flag wrong");

  sub_borrow_a: assert property (
    commit && instr_q.op == OP_PLAIN_DIFFERENCE
    |=> flags_q.c == ($past(acc) < $past(sel_opnd)))
    else $error("subtract borrow flag wrong");

  rotate_carry_a: assert property (
    commit && instr_q.op == OP_ROTATE_LEFT_THROUGH_CARRY
    |=> acc == 8'(($past(acc) << 1) | {7'h00, $past(flags_q.c)})
        && flags_q.c == ($past(acc) >> 7) && flags_q.z == $past(flags_q.z))
    else $error("rotate left through carry wrong");

  rotate_circ_a: assert property (
    commit && instr_q.op == OP_CIRCULAR_ROTATE_LEFT
    |=> acc == 8'(($past(acc) << 1) | ($past(acc) >> 7)) && flags_q.c == acc[0])
    else $error("circular rotate left wrong");

  result_flags_a: assert property (
    commit && op_writes_acc(instr_q.op) && op_sets_all_flags(instr_q.op)
    |=> flags_q.z == (acc == 8'h00) && flags_q.s == acc[7] && flags_q.p == ~^acc)
    else $error("zero, sign or parity flag wrong");

  mem_op_c: cover property (accept && instr_i.src == SRC_MEM);
  adjust_c: cover property (commit && instr_q.op == OP_DECIMAL_ADJUST && adj_flags.c);
  store_c: cover property (accept && instr_i.op == OP_INDIRECT_ACCUMULATOR_STORE);
  pair_carry_c: cover property (commit && instr_q.op == OP_PAIR_SUM_INTO_POINTER && pair_sum[16]);

endmodule

// ===== tb/accumulator_group_alu_tb.sv
// Self-checking bench for the accumulator-group execution unit.
// Assumes aga_pkg is compiled first; memory answers reads in the next cycle.
`timescale 1ns/1ps
module accumulator_group_alu_tb;
  import aga_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic issue_i = 1'b0;
  aga_instr_s instr_i = '0;
  logic ready_o, done_o;
  aga_mem_s mem_o;
  logic [7:0] mem_rdata_i = 8'h00;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [7:0] reg_rdata_o, acc_o;
  aga_flags_s flags_o;
  logic [7:0] mem_val = 8'h00;
  logic [15:0] ma = 16'h0000;
  logic [7:0] md = 8'h00;
  int fails = 0;
  int tests_run = 0;

  aga_core i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .issue_i(issue_i), .instr_i(instr_i),
    .ready_o(ready_o), .done_o(done_o), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .acc_o(acc_o), .flags_o(flags_o));

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  // Read data is valid only right after a read strobe; otherwise it keeps toggling.
  always @(posedge clk_i)
  begin
    mem_rdata_i <= mem_o.rd ? mem_val : ~mem_rdata_i;
    if (mem_o.rd || mem_o.wr)
    begin
      ma <= mem_o.addr;
      md <= mem_o.wdata;
    end
  end

  task automatic chk(logic [15:0] s, logic [15:0] e);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask

  // Issues one instruction, checks its state count, then accumulator and flags.
  task automatic ex(aga_op_e op, aga_src_e src, logic [2:0] sel, logic [15:0] b,
                    logic [3:0] n, logic [12:0] e);
    int k;
    @(posedge clk_i);
    issue_i <= 1'b1;
    instr_i <= '{op, src, sel, sel[1:0], b[7:0], b[15:8]};
    @(posedge clk_i);
    issue_i <= 1'b0;
    k = 1;
    #1;
    chk({15'h0000, ready_o}, 16'h0000);
    while (done_o !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk(16'(k), {12'h000, n});
    @(posedge clk_i);
    #1;
    chk({acc_o, flags_o}, e);
    chk({15'h0000, ready_o}, 16'h0001);
  endtask

  task automatic t_arith;
    wr(ADDR_A, 8'h3a);
    wr(4'h0, 8'hc6);
    wr(ADDR_FLAGS, 8'h00);
    ex(OP_PLAIN_SUM, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'h00, 5'h0f});
    ex(OP_SUM_WITH_CARRY, SRC_IMM, 3'h0, 16'h0010, 4'h7, {8'h11, 5'h02});
    ex(OP_CARRY_FORCE_ONE, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'h11, 5'h03});
    wr(4'h4, 8'h01);
    wr(ADDR_L, 8'h02);
    mem_val = 8'h20;
    ex(OP_SUBTRACT_WITH_BORROW, SRC_MEM, 3'h0, 16'h0000, 4'h7, {8'hf0, 5'h17});
    chk(ma, 16'h0102);
    ex(OP_PLAIN_DIFFERENCE, SRC_IMM, 3'h0, 16'h00f1, 4'h7, {8'hff, 5'h13});
    wr(4'h1, 8'hff);
    ex(OP_COMPARE, SRC_REG, 3'h1, 16'h0000, 4'h4, {8'hff, 5'h0e});
    $display("arithmetic test done");
  endtask

  task automatic t_logic;
    ex(OP_CARRY_FORCE_ONE, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'hff, 5'h0f});
    ex(OP_LOGICAL_AND, SRC_IMM, 3'h0, 16'h003c, 4'h7, {8'h3c, 5'h02});
    ex(OP_CARRY_FORCE_ONE, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'h3c, 5'h03});
    ex(OP_LOGICAL_OR, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'hfe, 5'h10});
    ex(OP_CARRY_FORCE_ONE, SRC_REG, 3'h0, 16'h0000, 4'h4, {8'hfe, 5'h11});
    mem_val = 8'hfe;
    ex(OP_EXCLUSIVE_OR, SRC_MEM, 3'h0, 16'h0000, 4'h7, {8'h00, 5'h0a});
    $display("logic test done");
  endtask

  task automatic t_rot;
    wr(ADDR_FLAGS, 8'hd4);
    wr(ADDR_A, 8'h81);
    ex(OP_ROTATE_LEFT_THROUGH_CARRY, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h02, 5'h1f});
    ex(OP_CIRCULAR_ROTATE_LEFT, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h04, 5'h1e});
    ex(OP_CIRCULAR_ROTATE_RIGHT, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h02, 5'h1e});
    ex(OP_CARRY_INVERT, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h02, 5'h1f});
    ex(OP_ROTATE_RIGHT_THROUGH_CARRY, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h81, 5'h1e});
    ex(OP_CIRCULAR_ROTATE_RIGHT, SRC_REG, 3'h0, 16'h0, 4'h4, {8'hc0, 5'h1f});
    ex(OP_ACCUMULATOR_INVERT, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h3f, 5'h1f});
    $display("rotate test done");
  endtask

  task automatic t_misc;
    wr(ADDR_A, 8'h9b);
    wr(ADDR_FLAGS, 8'h00);
    ex(OP_DECIMAL_ADJUST, SRC_REG, 3'h0, 16'h0, 4'h4, {8'h01, 5'h05});
    wr(4'h0, 8'h80);
    wr(4'h1, 8'h01);
    wr(4'h4, 8'h80);
    wr(ADDR_L, 8'hff);
    wr(ADDR_FLAGS, 8'h11);
    wr(ADDR_SPL, 8'h01);
    wr(ADDR_SPH, 8'h01);
    ex(OP_PAIR_SUM_INTO_POINTER, SRC_REG, 3'h3, 16'h0, 4'ha, {8'h01, 5'h04});
    ex(OP_PAIR_SUM_INTO_POINTER, SRC_REG, 3'h0, 16'h0, 4'ha, {8'h01, 5'h05});
    rd(4'h4, 8'h02);
    rd(ADDR_L, 8'h01);
    ex(OP_DIRECT_ACCUMULATOR_STORE, SRC_REG, 3'h0, 16'h1234, 4'hd, {8'h01, 5'h05});
    chk(ma, 16'h1234);
    chk({8'h00, md}, 16'h0001);
    mem_val = 8'h77;
    ex(OP_DIRECT_ACCUMULATOR_LOAD, SRC_REG, 3'h0, 16'h4321, 4'hd, {8'h77, 5'h05});
    chk(ma, 16'h4321);
    wr(4'h2, 8'h22);
    wr(4'h3, 8'h33);
    ex(OP_INDIRECT_ACCUMULATOR_STORE, SRC_REG, 3'h1, 16'h0, 4'h7, {8'h77, 5'h05});
    chk(ma, 16'h2233);
    chk({8'h00, md}, 16'h0077);
    mem_val = 8'h5a;
    ex(OP_INDIRECT_ACCUMULATOR_LOAD, SRC_REG, 3'h0, 16'h0, 4'h7, {8'h5a, 5'h05});
    chk(ma, 16'h8001);
    rd(ADDR_FLAGS, 8'h11);
    rd(4'ha, 8'h00);
    $display("transfer test done");
  endtask

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_arith();
    t_logic();
    t_rot();
    t_misc();
    conclude();
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    fails++;
    conclude();
  end
endmodule
